// File: shared/dmt_pkg.sv
// Constants and types for the dual multimode timer block.
// Assumes a 100 MHz system clock; all host pins are asynchronous.
`default_nettype none

package dmt_pkg;

   // ==========================================================
   // Register map
   localparam logic [4:0] ADR_MSR   = 5'h00;
   localparam logic [4:0] ADR_CTRL0 = 5'h01;
   localparam logic [4:0] ADR_CTRL1 = 5'h02;
   localparam logic [4:0] ADR_OMODE = 5'h02;
   localparam logic [4:0] ADR_D0_LO = 5'h0F;
   localparam logic [4:0] ADR_D0_HI = 5'h10;
   localparam logic [4:0] ADR_D1_LO = 5'h11;
   localparam logic [4:0] ADR_D1_HI = 5'h12;

   // ==========================================================
   // Field positions
   localparam int CTL_RUN   = 0;
   localparam int CTL_MODE  = 1;
   localparam int CTL_CLK   = 3;
   localparam int CTL_LATCH = 6;
   localparam int CTL_CHG   = 7;
   localparam int MSR_BANK  = 6;
   localparam int MSR_PAGE  = 7;
   localparam int OM_T0_INV = 0;
   localparam int OM_T0_OD  = 1;
   localparam int OM_T1_INV = 2;
   localparam int OM_T1_OD  = 3;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  CTRL_RST  = 8'h00;
   localparam logic [15:0] DATA_RST  = 16'h0000;
   localparam logic [7:0]  OMODE_RST = 8'h00;
   localparam logic [18:0] SYNC_RST  = 19'h00038;

   // ==========================================================
   // Timing
   localparam int SYS_CLK_NS = 10;
   localparam int T_93US_NS  = 93500;
   localparam int T_1MS_NS   = 1000000;
   localparam int T_10MS_NS  = 10000000;
   localparam int T_100MS_NS = 100000000;
   localparam int T_1S_NS    = 1000000000;
   localparam int CYC_93US   = T_93US_NS / SYS_CLK_NS;
   localparam int CYC_1MS    = T_1MS_NS / SYS_CLK_NS;
   localparam int CYC_10MS   = T_10MS_NS / SYS_CLK_NS;
   localparam int CYC_100MS  = T_100MS_NS / SYS_CLK_NS;
   localparam int CYC_1S     = T_1S_NS / SYS_CLK_NS;
   localparam int CYC_XTAL   = 20;
   localparam int PRE_W      = 27;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      MODE_PULSE  = 2'h0,
      MODE_RATE   = 2'h1,
      MODE_SQUARE = 2'h2,
      MODE_ONESHT = 2'h3
   } dmt_mode_t;

   typedef enum logic [2:0] {
      CK_EXT   = 3'h0,
      CK_XTAL  = 3'h1,
      CK_XTAL4 = 3'h2,
      CK_93US  = 3'h3,
      CK_1MS   = 3'h4,
      CK_10MS  = 3'h5,
      CK_100MS = 3'h6,
      CK_1S    = 3'h7
   } dmt_clk_t;

   typedef enum logic [1:0] {
      PH_STOP = 2'h0,
      PH_LOAD = 2'h1,
      PH_CNT  = 2'h3,
      PH_WAIT = 2'h2
   } dmt_phase_t;

endpackage : dmt_pkg

`default_nettype wire

// File: hdl/dmt_top.sv
// Two 16-bit down-counting timers behind a byte-wide host port.
// Assumes asynchronous host strobes and pins, synchronised here.
`default_nettype none

module dmt_top
   import dmt_pkg::*;
#(
   parameter logic [PRE_W-1:0] LAST_XTAL  = PRE_W'(CYC_XTAL - 1),
   parameter logic [PRE_W-1:0] LAST_XTAL4 = PRE_W'(4 * CYC_XTAL - 1),
   parameter logic [PRE_W-1:0] LAST_93US  = PRE_W'(CYC_93US - 1),
   parameter logic [PRE_W-1:0] LAST_1MS   = PRE_W'(CYC_1MS - 1),
   parameter logic [PRE_W-1:0] LAST_10MS  = PRE_W'(CYC_10MS - 1),
   parameter logic [PRE_W-1:0] LAST_100MS = PRE_W'(CYC_100MS - 1),
   parameter logic [PRE_W-1:0] LAST_1S    = PRE_W'(CYC_1S - 1)
)
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   input  wire logic       cs_n_i,
   input  wire logic       rd_n_i,
   input  wire logic       wr_n_i,
   input  wire logic [4:0] addr_i,
   input  wire logic [7:0] data_i,
   output var  logic [7:0] data_o,
   output var  logic       data_oe_o,
   input  wire logic       tck_i,
   input  wire logic       gate_in_0_i,
   input  wire logic       gate_in_1_i,
   output var  logic       multi_function_out_o,
   output var  logic       multi_function_out_oe_o,
   output var  logic       timer1_out_o,
   output var  logic       timer1_out_oe_o,
   output var  logic       timer0_zero_o,
   output var  logic       timer1_zero_o
);

   // ==========================================================
   // Pin synchronisers
   logic [18:0]    meta_r;
   logic [18:0]    sync_r;
   logic           wr_act_q;
   logic           rd_act_q;
   logic           tck_q;
   logic [1:0]     gate_q;
   logic [4:0]     wa_r;
   logic [7:0]     wd_r;
   logic [4:0]     ra_r;

   logic [7:0]     s_data;
   logic [4:0]     s_addr;
   logic           s_tck;
   logic [1:0]     s_gate;
   logic           wr_act;
   logic           rd_act;
   logic           wr_commit;
   logic           rd_end;

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_r <= SYNC_RST;
         sync_r <= SYNC_RST;
      end
      else
      begin
         meta_r <= {data_i, addr_i, cs_n_i, rd_n_i, wr_n_i,
                    tck_i, gate_in_1_i, gate_in_0_i};
         sync_r <= meta_r;
      end
   end

   assign s_data    = sync_r[18:11];
   assign s_addr    = sync_r[10:6];
   assign s_tck     = sync_r[2];
   assign s_gate    = sync_r[1:0];
   assign wr_act    = ~sync_r[5] & ~sync_r[3];
   assign rd_act    = ~sync_r[5] & ~sync_r[4];
   assign wr_commit = wr_act_q & ~wr_act;
   assign rd_end    = rd_act_q & ~rd_act;

   // Address and data are captured while a strobe is active, because
   // they may change in the same cycle as the strobe releases.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_act_q <= 1'b0;
         rd_act_q <= 1'b0;
         tck_q    <= 1'b0;
         gate_q   <= 2'h0;
         wa_r     <= 5'h00;
         wd_r     <= 8'h00;
         ra_r     <= 5'h00;
      end
      else
      begin
         wr_act_q <= wr_act;
         rd_act_q <= rd_act;
         tck_q    <= s_tck;
         gate_q   <= s_gate;
         if (wr_act)
         begin
            wa_r <= s_addr;
            wd_r <= s_data;
         end
         if (rd_act)
         begin
            ra_r <= s_addr;
         end
      end
   end

   // ==========================================================
   // Register storage
   logic [7:0]          ctrl_r [2];
   logic [15:0]         data_r [2];
   logic [15:0]         hold_r [2];
   logic [1:0]          cap_r;
   logic [7:0]          om_r;
   logic                page_r;
   logic                bank_r;
   logic [15:0]         cnt_r  [2];
   logic [PRE_W-1:0]    pre_r  [2];
   dmt_phase_t          ph_r   [2];
   logic [1:0]          out_r;

   logic [1:0]          wr_ctrl;
   logic [1:0]          rd_lo_end;
   logic [1:0]          zero_ev;
   logic [1:0]          tick;
   logic [1:0]          trig;
   logic [1:0]          hold;

   function automatic logic is_ctrl(input logic [4:0] a,
                                    input int         i);
      is_ctrl = ~page_r & ~bank_r &
                (a == ((i == 0) ? ADR_CTRL0 : ADR_CTRL1));
   endfunction : is_ctrl

   function automatic logic [PRE_W-1:0] clk_last(input dmt_clk_t s);
      logic [PRE_W-1:0] v;
      v = LAST_1S;
      unique case (s)
         CK_EXT:   v = '0;
         CK_XTAL:  v = LAST_XTAL;
         CK_XTAL4: v = LAST_XTAL4;
         CK_93US:  v = LAST_93US;
         CK_1MS:   v = LAST_1MS;
         CK_10MS:  v = LAST_10MS;
         CK_100MS: v = LAST_100MS;
         CK_1S:    v = LAST_1S;
      endcase
      clk_last = v;
   endfunction : clk_last

   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         wr_ctrl[i]   = wr_commit & is_ctrl(wa_r, i);
         rd_lo_end[i] = rd_end & ~page_r &
                        (ra_r == ((i == 0) ? ADR_D0_LO : ADR_D1_LO));
      end
   end

   // Page, bank and output configuration.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         page_r <= 1'b0;
         bank_r <= 1'b0;
         om_r   <= OMODE_RST;
      end
      else if (wr_commit)
      begin
         if (wa_r == ADR_MSR)
         begin
            page_r <= wd_r[MSR_PAGE];
            bank_r <= wd_r[MSR_BANK];
         end
         else if (~page_r & bank_r & (wa_r == ADR_OMODE))
         begin
            om_r <= wd_r;
         end
      end
   end

   // Control registers: host writes win over the hardware clears.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 2; i++)
         begin
            ctrl_r[i] <= CTRL_RST;
         end
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (wr_ctrl[i])
            begin
               ctrl_r[i] <= wd_r;
            end
            else
            begin
               if (zero_ev[i] &&
                   dmt_mode_t'(ctrl_r[i][CTL_MODE +: 2]) == MODE_PULSE)
               begin
                  ctrl_r[i][CTL_RUN] <= 1'b0;
               end
               if (rd_lo_end[i])
               begin
                  ctrl_r[i][CTL_LATCH] <= 1'b0;
               end
            end
         end
      end
   end

   // Preset data registers.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         data_r[0] <= DATA_RST;
         data_r[1] <= DATA_RST;
      end
      else if (wr_commit && !page_r)
      begin
         unique case (wa_r)
            ADR_D0_LO: data_r[0][7:0]  <= wd_r;
            ADR_D0_HI: data_r[0][15:8] <= wd_r;
            ADR_D1_LO: data_r[1][7:0]  <= wd_r;
            ADR_D1_HI: data_r[1][15:8] <= wd_r;
            default:   ;
         endcase
      end
   end

   // ==========================================================
   // Clock selection and prescalers
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         hold[i] = (ctrl_r[i][CTL_CHG] | s_gate[i]) &
                   (dmt_mode_t'(ctrl_r[i][CTL_MODE +: 2])
                    != MODE_ONESHT);
         trig[i] = (dmt_mode_t'(ctrl_r[i][CTL_MODE +: 2])
                    == MODE_ONESHT) &
                   ((s_gate[i] & ~gate_q[i]) |
                    (wr_ctrl[i] & wd_r[CTL_CHG]));
         if (dmt_clk_t'(ctrl_r[i][CTL_CLK +: 3]) == CK_EXT)
         begin
            tick[i] = tck_q & ~s_tck & ~hold[i];
         end
         else
         begin
            tick[i] = ~hold[i] & (pre_r[i] >=
                      clk_last(dmt_clk_t'(ctrl_r[i][CTL_CLK +: 3])));
         end
      end
   end

   // The prescaler restarts from zero on every start, so with an internal
   // clock the first tick comes one full period after the run bit is set
   // (with CK_EXT it comes on the next falling tck edge). A hold
   // freezes it without clearing it.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pre_r[0] <= '0;
         pre_r[1] <= '0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (!ctrl_r[i][CTL_RUN] ||
                dmt_clk_t'(ctrl_r[i][CTL_CLK +: 3]) == CK_EXT)
            begin
               pre_r[i] <= '0;
            end
            else if (!hold[i])
            begin
               pre_r[i] <= tick[i] ? '0 : pre_r[i] + 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Counting engines
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         zero_ev[i] = 1'b0;
         if (ctrl_r[i][CTL_RUN] && ph_r[i] == PH_CNT &&
             tick[i] && !trig[i])
         begin
            unique case (dmt_mode_t'(ctrl_r[i][CTL_MODE +: 2]))
               MODE_PULSE:  zero_ev[i] = cnt_r[i] <= 16'h0001;
               MODE_RATE:   zero_ev[i] = cnt_r[i] == 16'h0001;
               MODE_SQUARE: zero_ev[i] = (cnt_r[i] == 16'h0000) &
                                         out_r[i];
               MODE_ONESHT: zero_ev[i] = cnt_r[i] <= 16'h0001;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 2; i++)
         begin
            ph_r[i]  <= PH_STOP;
            cnt_r[i] <= 16'h0000;
         end
         out_r <= 2'h0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (!ctrl_r[i][CTL_RUN])
            begin
               ph_r[i]  <= PH_STOP;
               cnt_r[i] <= 16'h0000;
               out_r[i] <= 1'b0;
            end
            else
            begin
               unique case (ph_r[i])
                  PH_STOP:
                  begin
                     ph_r[i] <= (dmt_mode_t'(ctrl_r[i][CTL_MODE +: 2])
                                 == MODE_ONESHT) ? PH_WAIT : PH_LOAD;
                  end
                  PH_WAIT:
                  begin
                     if (trig[i])
                     begin
                        out_r[i] <= 1'b1;
                        ph_r[i]  <= PH_LOAD;
                     end
                  end
                  PH_LOAD:
                  begin
                     if (tick[i])
                     begin
                        cnt_r[i] <= data_r[i];
                        out_r[i] <= 1'b1;
                        ph_r[i]  <= PH_CNT;
                     end
                  end
                  PH_CNT:
                  begin
                     if (trig[i])
                     begin
                        ph_r[i] <= PH_LOAD;
                     end
                     else if (tick[i])
                     begin
                        unique case (dmt_mode_t'(ctrl_r[i][CTL_MODE +: 2]))
                           MODE_PULSE, MODE_ONESHT:
                           begin
                              if (cnt_r[i] <= 16'h0001)
                              begin
                                 cnt_r[i] <= 16'h0000;
                                 out_r[i] <= 1'b0;
                                 ph_r[i]  <= (dmt_mode_t'(ctrl_r[i]
                                             [CTL_MODE +: 2]) ==
                                             MODE_ONESHT) ?
                                             PH_WAIT : PH_STOP;
                              end
                              else
                              begin
                                 cnt_r[i] <= cnt_r[i] - 16'h0001;
                              end
                           end
                           MODE_RATE:
                           begin
                              if (cnt_r[i] == 16'h0000)
                              begin
                                 cnt_r[i] <= data_r[i];
                                 out_r[i] <= 1'b1;
                              end
                              else
                              begin
                                 cnt_r[i] <= cnt_r[i] - 16'h0001;
                                 if (cnt_r[i] == 16'h0001)
                                 begin
                                    out_r[i] <= 1'b0;
                                 end
                              end
                           end
                           MODE_SQUARE:
                           begin
                              if (cnt_r[i] == 16'h0000)
                              begin
                                 cnt_r[i] <= data_r[i];
                                 out_r[i] <= ~out_r[i];
                              end
                              else
                              begin
                                 cnt_r[i] <= cnt_r[i] - 16'h0001;
                              end
                           end
                        endcase
                     end
                  end
               endcase
            end
         end
      end
   end

   // A capture waits for a cycle with no tick, so it never sees
   // the counter mid-update.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cap_r     <= 2'h0;
         hold_r[0] <= 16'h0000;
         hold_r[1] <= 16'h0000;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (!ctrl_r[i][CTL_LATCH])
            begin
               cap_r[i] <= 1'b0;
            end
            else if (!cap_r[i] && !tick[i])
            begin
               hold_r[i] <= cnt_r[i];
               cap_r[i]  <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Host read path
   logic [7:0] rd_mux;

   always_comb
   begin
      rd_mux = 8'h00;
      if (s_addr == ADR_MSR)
      begin
         rd_mux = {page_r, bank_r, 6'h00};
      end
      else if (!page_r)
      begin
         unique case (s_addr)
            ADR_CTRL0: rd_mux = bank_r ? 8'h00 : ctrl_r[0];
            ADR_CTRL1: rd_mux = bank_r ? om_r : ctrl_r[1];
            ADR_D0_LO: rd_mux = cap_r[0] ? hold_r[0][7:0]
                                         : data_r[0][7:0];
            ADR_D0_HI: rd_mux = cap_r[0] ? hold_r[0][15:8]
                                         : data_r[0][15:8];
            ADR_D1_LO: rd_mux = cap_r[1] ? hold_r[1][7:0]
                                         : data_r[1][7:0];
            ADR_D1_HI: rd_mux = cap_r[1] ? hold_r[1][15:8]
                                         : data_r[1][15:8];
            default:   rd_mux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         data_o    <= 8'h00;
         data_oe_o <= 1'b0;
      end
      else
      begin
         data_oe_o <= rd_act;
         data_o    <= rd_act ? rd_mux : 8'h00;
      end
   end

   // ==========================================================
   // Output pins
   logic [1:0] lvl;

   assign lvl[0] = out_r[0] ^ om_r[OM_T0_INV];
   assign lvl[1] = out_r[1] ^ om_r[OM_T1_INV];

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         multi_function_out_o    <= 1'b0;
         multi_function_out_oe_o <= 1'b0;
         timer1_out_o            <= 1'b0;
         timer1_out_oe_o         <= 1'b0;
         timer0_zero_o           <= 1'b0;
         timer1_zero_o           <= 1'b0;
      end
      else
      begin
         multi_function_out_o    <= ~om_r[OM_T0_OD] & lvl[0];
         multi_function_out_oe_o <= ~om_r[OM_T0_OD] | ~lvl[0];
         timer1_out_o            <= ~om_r[OM_T1_OD] & lvl[1];
         timer1_out_oe_o         <= ~om_r[OM_T1_OD] | ~lvl[1];
         timer0_zero_o           <= zero_ev[0];
         timer1_zero_o           <= zero_ev[1];
      end
   end

endmodule : dmt_top

`default_nettype wire

// File: tb/dmt_checker.sv
// Pin-level checker for the dual timer top module.
// Assumes it is bound into dmt_top and sees only its ports.
`default_nettype none
module dmt_checker
(
   input wire logic       sys_clk_i,
   input wire logic       rst_i,
   input wire logic       cs_n_i,
   input wire logic       rd_n_i,
   input wire logic [7:0] data_o,
   input wire logic       data_oe_o,
   input wire logic       multi_function_out_o,
   input wire logic       multi_function_out_oe_o,
   input wire logic       timer1_out_o,
   input wire logic       timer1_out_oe_o,
   input wire logic       timer0_zero_o,
   input wire logic       timer1_zero_o
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   property p_rd_on; !cs_n_i && !rd_n_i |-> ##3 data_oe_o; endproperty
   a_rd_on: assert property (p_rd_on) else $error("read not driven");
   property p_rd_off; cs_n_i || rd_n_i |-> ##3 !data_oe_o; endproperty
   a_rd_off: assert property (p_rd_off) else $error("bus held");
   property p_quiet; !data_oe_o |-> data_o == 8'h00; endproperty
   a_quiet: assert property (p_quiet) else $error("idle data");
   property p_fall; $fell(data_oe_o) |-> $past(cs_n_i || rd_n_i, 3);
   endproperty
   a_fall: assert property (p_fall) else $error("early release");
   // Open drain never drives high, so a high level needs the enable.
   property p_od0;
      multi_function_out_o |-> multi_function_out_oe_o;
   endproperty
   a_od0: assert property (p_od0) else $error("pin 0 drive");
   property p_od1; timer1_out_o |-> timer1_out_oe_o; endproperty
   a_od1: assert property (p_od1) else $error("pin 1 drive");
   property p_z0; timer0_zero_o |=> !timer0_zero_o; endproperty
   a_z0: assert property (p_z0) else $error("zero 0 width");
   property p_z1; timer1_zero_o |=> !timer1_zero_o; endproperty
   a_z1: assert property (p_z1) else $error("zero 1 width");
   c_z0: cover property (timer0_zero_o);
   c_z1: cover property (timer1_zero_o);
   c_rd: cover property ($rose(data_oe_o));
endmodule : dmt_checker
bind dmt_top dmt_checker dmt_checker_i (.sys_clk_i, .rst_i, .cs_n_i,
   .rd_n_i, .data_o, .data_oe_o, .multi_function_out_o,
   .multi_function_out_oe_o, .timer1_out_o, .timer1_out_oe_o,
   .timer0_zero_o, .timer1_zero_o);
`default_nettype wire

// File: tb/dmt_host.sv
// Host processor model driving the byte-wide register port.
// Assumes a running bench clock and reset already released.
`default_nettype none
module dmt_host
   import dmt_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output var  logic       cs_n_o,
   output var  logic       rd_n_o,
   output var  logic       wr_n_o,
   output var  logic [4:0] addr_o,
   output var  logic [7:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
      addr_o = 5'h00;
      wdata_o = 8'h00;
   end
   // ==========================================================
   // Bus cycles
   // Strobes stay low five cycles because the pins are synchronised.
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      {cs_n_o, wr_n_o} <= 2'h0;
      repeat (5) @(posedge clk_i);
      {cs_n_o, wr_n_o} <= 2'h3;
      repeat (3) @(posedge clk_i);
      wdata_o <= ~d;
      repeat (3) @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [7:0] q);
      @(posedge clk_i);
      addr_o <= a;
      {cs_n_o, rd_n_o} <= 2'h0;
      repeat (5) @(posedge clk_i);
      q = rdata_i;
      {cs_n_o, rd_n_o} <= 2'h3;
      repeat (6) @(posedge clk_i);
   endtask : rd
   // A zero-count single pulse clears a stale trigger before one shot.
   task automatic arm();
      wr(ADR_D1_LO, 8'h00);
      wr(ADR_CTRL1, 8'h08);
      wr(ADR_CTRL1, 8'h09);
      repeat (60) @(posedge clk_i);
   endtask : arm
endmodule : dmt_host
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench: host model, pin checker and a timing model.
// Assumes package, design, host and checker are compiled first.
`default_nettype none
module tb
   import dmt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       tck = 1'b0;
   logic       g0 = 1'b0;
   logic       g1 = 1'b0;
   logic       cs_n, rd_n, wr_n, oe, mfo_oe, t1_oe;
   logic [1:0] z, p;
   logic [4:0] addr;
   logic [7:0] wdata, rdata, q;
   int         err_total, compares, n, c, tdiv;
   int         per [8] = '{10, 20, 80, 6, 8, 12, 14, 20};
   dmt_host dmt_host_i (.clk_i(clk), .rdata_i(rdata), .cs_n_o(cs_n),
      .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));
   // Crystal choices keep their defaults: they follow the crystal.
   dmt_top #(.LAST_93US(27'h5),
      .LAST_1MS(27'h7), .LAST_10MS(27'hB), .LAST_100MS(27'hD),
      .LAST_1S(27'h13)) dmt_top_i (.sys_clk_i(clk), .rst_i(rst),
      .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr),
      .data_i(wdata), .data_o(rdata), .data_oe_o(oe), .tck_i(tck),
      .gate_in_0_i(g0), .gate_in_1_i(g1), .multi_function_out_o(p[0]),
      .multi_function_out_oe_o(mfo_oe), .timer1_out_o(p[1]),
      .timer1_out_oe_o(t1_oe), .timer0_zero_o(z[0]), .timer1_zero_o(z[1]));
   initial
   begin
      forever #5 clk = ~clk;
   end
   // The external clock runs free, ten system cycles a period.
   always @(posedge clk)
   begin
      tdiv <= (tdiv == 4) ? 0 : tdiv + 1;
      if (tdiv == 4)
         tck <= ~tck;
   end
   // ==========================================================
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int t, input int lim, output int k);
      k = 1;
      @(negedge clk);
      while (z[t] !== 1'b1 && k < lim) @(negedge clk) k++;
   endtask : wt
   task automatic gap(input int t, output int k);
      wt(t, 3000, k);
      wt(t, 3000, k);
   endtask : gap
   task automatic hi(input int t, output int k);
      k = 0;
      while (p[t] !== 1'b0 && k < 900) @(negedge clk) k++;
      while (p[t] !== 1'b1 && k < 1800) @(negedge clk) k++;
      k = 0;
      while (p[t] === 1'b1 && k < 900) @(negedge clk) k++;
   endtask : hi
   task automatic results();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   // The whole run needs well under a tenth of this span.
   initial
   begin
      #(1_000_000);
      err_total++;
      results();
   end
   initial
   begin
      n = $urandom(32'h85DB11D2);
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      n = $urandom_range(6, 2);
      dmt_host_i.wr(ADR_D0_LO, 8'(n));
      dmt_host_i.rd(ADR_D0_LO, q);
      chk(q, n);
      for (int s = 0; s < 8; s++)
      begin
         dmt_host_i.wr(ADR_CTRL0, 8'(s * 8 + 2));
         dmt_host_i.wr(ADR_CTRL0, 8'(s * 8 + 3));
         gap(0, c);
         chk(c, (n + 1) * per[s]);
      end
      $display("rate test done");
      dmt_host_i.wr(ADR_CTRL0, 8'h38);
      dmt_host_i.wr(ADR_CTRL0, 8'h39);
      hi(0, c);
      chk(c, n * 20);
      dmt_host_i.rd(ADR_CTRL0, q);
      chk(q, 8'h38);
      $display("pulse test done");
      dmt_host_i.wr(ADR_D1_LO, 8'(n));
      dmt_host_i.wr(ADR_CTRL1, 8'h0C);
      dmt_host_i.wr(ADR_CTRL1, 8'h0D);
      gap(1, c);
      chk(c, 2 * per[1] * (n + 1));
      hi(1, c);
      chk(c, per[1] * (n + 1));
      $display("square test done");
      dmt_host_i.wr(ADR_CTRL0, 8'h0A);
      dmt_host_i.wr(ADR_CTRL0, 8'h0B);
      g0 <= 1'b1;
      repeat (4) @(posedge clk);
      wt(0, 200, c);
      chk(c, 200);
      @(posedge clk);
      g0 <= 1'b0;
      dmt_host_i.wr(ADR_CTRL0, 8'h8B);
      wt(0, 200, c);
      chk(c, 200);
      dmt_host_i.wr(ADR_CTRL0, 8'h0B);
      gap(0, c);
      chk(c, per[1] * (n + 1));
      // Hold freezes the count, so the capture is a value in 0..n.
      dmt_host_i.wr(ADR_CTRL0, 8'hCB);
      dmt_host_i.rd(ADR_D0_LO, q);
      chk(q <= n, 1'b1);
      dmt_host_i.rd(ADR_D0_LO, q);
      chk(q, n);
      $display("hold test done");
      dmt_host_i.arm();
      dmt_host_i.wr(ADR_D1_LO, 8'(n));
      dmt_host_i.wr(ADR_CTRL1, 8'h0E);
      dmt_host_i.wr(ADR_CTRL1, 8'h0F);
      wt(1, 100, c);
      chk(c, 100);
      @(posedge clk);
      g1 <= 1'b1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk(p[1], 1'b1);
      @(posedge clk);
      g1 <= 1'b0;
      repeat (2) @(posedge clk);
      g1 <= 1'b1;
      wt(1, 400, c);
      c = c - per[1] * n;
      chk(c >= 4 && c <= per[1] + 4, 1'b1);
      $display("one shot test done");
      dmt_host_i.wr(ADR_CTRL0, 8'h0A);
      dmt_host_i.wr(ADR_MSR, 8'h40);
      for (int m = 0; m < 4; m++)
      begin
         dmt_host_i.wr(ADR_OMODE, 8'(m * 5));
         @(negedge clk);
         chk({p[0], mfo_oe}, (m == 3) ? 0 : ((m == 1) ? 3 : 1));
         chk({p[1], t1_oe}, (m == 3) ? 0 : ((m == 1) ? 3 : 1));
      end
      $display("output mode test done");
      results();
   end
endmodule : tb
`default_nettype wire
